// *** design/flash_user_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_user_ctrl #(
  parameter int unsigned PROG_TIMEOUT  = flash_pkg::PROG_MAX_CYC,
  parameter int unsigned ERASE_TIMEOUT = flash_pkg::ERASE_MAX_CYC
) (
  input  wire logic           clock,   // 50 MHz system clock
  input  wire logic           rst,     // async reset, active high
  input  wire logic           ce,      // clock enable, freezes all state
  flash_link_if.user_end      link,    // link to flash block
  input  wire logic           start,   // start pulse, taken when ready
  input  wire flash_pkg::op_e op,      // operation
  input  wire flash_pkg::addr_t addr,  // word address
  input  wire flash_pkg::word_t wdata, // word to program
  output logic                ready,   // idle, accepts start
  output logic                done,    // one-cycle completion pulse
  output logic                timeout, // sticky, busy late or too long
  output flash_pkg::word_t    rdata    // word read back
);
  import flash_pkg::*;

  typedef enum logic [9:0] {
    H_IDLE  = 10'h001,
    H_ADDR  = 10'h002,
    H_DATA  = 10'h004,
    H_LOAD  = 10'h008,
    H_READ  = 10'h010,
    H_LEAD  = 10'h020,
    H_RISE  = 10'h040,
    H_FALL  = 10'h080,
    H_HOLD  = 10'h100,
    H_TAIL  = 10'h200
  } hstate_e;

  hstate_e state;
  op_e     op_q;
  word_t   shreg;
  word_t   wdata_q;
  cnt_t    cnt;
  cnt_t    phase;
  logic [4:0] bits;
  logic    last_phase;
  logic    shifting;

  // serial clocks: low half then high half, each at least the half period
  assign last_phase = (phase == cnt_t'(2 * SCLK_HALF - 1));
  assign shifting = (state == H_ADDR) || (state == H_DATA) ||
                    (state == H_LOAD) || (state == H_READ);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase <= '0;
    end else if (ce) begin
      if (!shifting || last_phase) begin
        phase <= '0;
      end else begin
        phase <= phase + cnt_t'(1);
      end
    end
  end

  // pin drive: clocks rise at the half phase, giving setup and hold
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link.arclk      <= 1'b0;
      link.drclk      <= 1'b0;
      link.addr_shift <= 1'b0;
      link.data_shift <= 1'b0;
      link.addr_in    <= 1'b0;
      link.data_in    <= 1'b0;
    end else if (ce) begin
      link.addr_shift <= (state == H_ADDR);
      link.data_shift <= (state == H_DATA) || (state == H_READ);
      link.addr_in    <= shreg[DATA_W-1];
      link.data_in    <= (state == H_DATA) ? shreg[DATA_W-1] : 1'b0;
      link.arclk      <= (state == H_ADDR) && (phase >= cnt_t'(SCLK_HALF));
      link.drclk      <= (state == H_DATA || state == H_LOAD || state == H_READ)
                         && (phase >= cnt_t'(SCLK_HALF));
    end
  end

  // sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state   <= H_IDLE;
      op_q    <= OP_READ;
      shreg   <= '0;
      wdata_q <= '0;
      cnt     <= '0;
      bits    <= '0;
      ready   <= 1'b1;
      done    <= 1'b0;
      timeout <= 1'b0;
      rdata   <= '0;
      link.prog_req  <= 1'b0;
      link.erase_req <= 1'b0;
      link.oscillator_enable <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      unique case (state)
        H_IDLE: begin
          if (start) begin
            op_q    <= op;
            wdata_q <= wdata;
            shreg   <= {addr, {(DATA_W-ADDR_W){1'b0}}};
            bits    <= 5'(ADDR_W - 1);
            ready   <= 1'b0;
            state   <= H_ADDR;
          end
        end
        H_ADDR: begin
          if (last_phase) begin
            shreg <= {shreg[DATA_W-2:0], 1'b0};
            bits  <= bits - 5'h01;
            if (bits == 5'h00) begin
              unique case (op_q)
                OP_READ: state <= H_LOAD;
                OP_PROG: begin
                  shreg <= wdata_q;
                  bits  <= 5'(DATA_W - 1);
                  state <= H_DATA;
                end
                default: begin
                  link.oscillator_enable <= 1'b1;
                  cnt   <= cnt_t'(OSCS_CYC);
                  state <= H_LEAD;
                end
              endcase
            end
          end
        end
        H_DATA: begin
          if (last_phase) begin
            shreg <= {shreg[DATA_W-2:0], 1'b0};
            bits  <= bits - 5'h01;
            if (bits == 5'h00) begin
              link.oscillator_enable <= 1'b1;
              cnt   <= cnt_t'(OSCS_CYC);
              state <= H_LEAD;
            end
          end
        end
        H_LOAD: begin
          if (last_phase) begin
            bits  <= 5'(DATA_W - 1);
            state <= H_READ;
          end
        end
        H_READ: begin
          // sample the msb just before each rising edge shifts it on
          if (phase == cnt_t'(SCLK_HALF - 1)) begin
            shreg <= {shreg[DATA_W-2:0], link.data_out};
          end
          if (last_phase) begin
            bits <= bits - 5'h01;
            if (bits == 5'h00) begin
              rdata <= shreg;
              done  <= 1'b1;
              ready <= 1'b1;
              state <= H_IDLE;
            end
          end
        end
        H_LEAD: begin
          cnt <= cnt - cnt_t'(1);
          if (cnt == cnt_t'(1)) begin
            link.prog_req  <= (op_q == OP_PROG);
            link.erase_req <= (op_q == OP_ERASE);
            cnt   <= cnt_t'(PB_CYC);
            state <= H_RISE;
          end
        end
        H_RISE: begin
          cnt <= cnt - cnt_t'(1);
          if (link.busy) begin
            cnt   <= (op_q == OP_PROG) ? cnt_t'(PROG_TIMEOUT) : cnt_t'(ERASE_TIMEOUT);
            state <= H_FALL;
          end else if (cnt == cnt_t'(0)) begin
            timeout <= 1'b1;
            cnt     <= cnt_t'(BP_CYC);
            state   <= H_HOLD;
          end
        end
        H_FALL: begin
          // the request stays up until busy has fallen or the timeout count runs out
          cnt <= cnt - cnt_t'(1);
          if (!link.busy || cnt == cnt_t'(0)) begin
            timeout <= timeout | link.busy;
            cnt     <= cnt_t'(BP_CYC);
            state   <= H_HOLD;
          end
        end
        H_HOLD: begin
          cnt <= cnt - cnt_t'(1);
          if (cnt == cnt_t'(1)) begin
            link.prog_req  <= 1'b0;
            link.erase_req <= 1'b0;
            cnt   <= cnt_t'(OSCS_CYC);
            state <= H_TAIL;
          end
        end
        H_TAIL: begin
          cnt <= cnt - cnt_t'(1);
          if (cnt == cnt_t'(1)) begin
            link.oscillator_enable <= 1'b0;
            done  <= 1'b1;
            ready <= 1'b1;
            state <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** design/flash_pkg.sv ***
`default_nettype none
package flash_pkg;
  // link geometry
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CNT_W  = 25;
  localparam int unsigned MEM_WORDS = 1 << ADDR_W;
  typedef logic [CNT_W-1:0]  cnt_t;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] word_t;

  // system clock
  localparam int unsigned CLK_NS = 20;

  // least time: round up, never under one cycle
  function automatic int unsigned cyc_min(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // longest time: round down, never under one cycle
  function automatic int unsigned cyc_max(input int unsigned ns);
    int unsigned c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // documented times, in their own units
  localparam int unsigned T_SCLK_NS  = 100;
  localparam int unsigned T_PB_NS    = 960;
  localparam int unsigned T_BP_NS    = 20;
  localparam int unsigned T_PPMX_US  = 100;
  localparam int unsigned T_EPMX_MS  = 500;
  localparam int unsigned T_DCO_NS   = 5;
  localparam int unsigned T_OE_NS    = 180;
  localparam int unsigned T_RA_NS    = 65;
  localparam int unsigned T_OSCS_NS  = 250;

  // derived cycle counts
  localparam int unsigned SCLK_CYC   = cyc_min(T_SCLK_NS);
  localparam int unsigned SCLK_HALF  = (SCLK_CYC + 1) / 2;
  localparam int unsigned PB_CYC     = cyc_max(T_PB_NS);
  localparam int unsigned BP_CYC     = cyc_min(T_BP_NS);
  localparam int unsigned PROG_MAX_CYC  = T_PPMX_US * 1000 / CLK_NS;
  localparam int unsigned ERASE_MAX_CYC = T_EPMX_MS * 1000 * (1000 / CLK_NS);
  localparam int unsigned DCO_CYC    = cyc_max(T_DCO_NS);
  localparam int unsigned OE_CYC     = cyc_min(T_OE_NS);
  localparam int unsigned RA_CYC     = cyc_max(T_RA_NS);
  localparam int unsigned OSCS_CYC   = cyc_min(T_OSCS_NS);

  // device-side choices within the limits above
  localparam int unsigned BUSY_LAG_CYC = 2;
  localparam int unsigned OSC_HALF_CYC = 5;

  // host operations
  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_PROG  = 2'h1,
    OP_ERASE = 2'h2
  } op_e;
endpackage
`default_nettype wire

// *** design/flash_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface flash_link_if;
  logic arclk;             // address register serial clock
  logic addr_shift;        // address register shift enable
  logic addr_in;           // address serial data
  logic drclk;             // data register serial clock
  logic data_shift;        // 1 shift, 0 load from array
  logic data_in;           // data serial in
  logic data_out;          // data serial out, msb of data register
  logic prog_req;          // program request
  logic erase_req;         // erase request
  logic busy;              // operation in progress
  logic oscillator_enable; // oscillator run request
  logic osc_clk;           // oscillator output

  modport user_end (
    output arclk, addr_shift, addr_in, drclk, data_shift, data_in,
    output prog_req, erase_req, oscillator_enable,
    input  data_out, busy, osc_clk
  );
  modport flash_end (
    input  arclk, addr_shift, addr_in, drclk, data_shift, data_in,
    input  prog_req, erase_req, oscillator_enable,
    output data_out, busy, osc_clk
  );
endinterface
`default_nettype wire

// *** design/user_flash_block.sv ***
`timescale 1ns/1ps
`default_nettype none
// Contract
// - user address clock period at least 100 ns
// - user data clock period at least 100 ns
// - busy rises within 960 ns of program
// - program held until 20 ns after busy
// - program busy pulse at most 100 us
// - busy rises within 960 ns of erase
// - erase held until 20 ns after busy
// - erase busy pulse at most 500 ms
// - data output follows clock within 5 ns; here data_out moves one 20 ns system clock after the drclk rise
// - oscillator first rises 180 ns after enable
// - read data valid within 65 ns
// - oscillator enabled 250 ns before request
// - oscillator kept 250 ns after request
module user_flash_block #(
  parameter int unsigned PROG_CYCLES  = flash_pkg::PROG_MAX_CYC,
  parameter int unsigned ERASE_CYCLES = flash_pkg::ERASE_MAX_CYC
) (
  input  wire logic      clock,    // 50 MHz system clock
  input  wire logic      rst,      // async reset, active high
  input  wire logic      ce,       // clock enable, freezes all state
  flash_link_if.flash_end link,    // link from user logic
  output logic           idle,     // no operation running
  output logic           refused   // sticky, request seen without oscillator
);
  import flash_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE    = 5'h01,
    S_LAG     = 5'h02,
    S_PROG    = 5'h04,
    S_ERASE   = 5'h08,
    S_RELEASE = 5'h10
  } fstate_e;

  fstate_e state;
  word_t   mem [MEM_WORDS];
  addr_t   addr_reg;
  word_t   data_reg;
  cnt_t    op_cnt;
  cnt_t    osc_cnt;
  logic    arclk_q;
  logic    drclk_q;
  logic    prog_q;
  logic    erase_q;
  logic    a_rise;
  logic    d_rise;
  logic    p_rise;
  logic    e_rise;
  logic    op_erase;
  logic    commit;
  logic    osc_started;

  // the far end runs on this clock, so its pins need no synchroniser
  assign a_rise = link.arclk & ~arclk_q;
  assign d_rise = link.drclk & ~drclk_q;
  assign p_rise = link.prog_req & ~prog_q;
  assign e_rise = link.erase_req & ~erase_q;

  // edge history
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      arclk_q <= 1'b0;
      drclk_q <= 1'b0;
      prog_q  <= 1'b0;
      erase_q <= 1'b0;
    end else if (ce) begin
      arclk_q <= link.arclk;
      drclk_q <= link.drclk;
      prog_q  <= link.prog_req;
      erase_q <= link.erase_req;
    end
  end

  // address register; shifting is ignored while an operation runs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_reg <= '0;
    end else if (ce) begin
      if (a_rise && link.addr_shift && state == S_IDLE) begin
        addr_reg <= {addr_reg[ADDR_W-2:0], link.addr_in};
      end
    end
  end

  // data register: shift on a clock edge, or load the addressed word
  // in the same edge, so the msb is out one cycle later
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_reg <= '0;
    end else if (ce) begin
      if (d_rise && state == S_IDLE) begin
        if (link.data_shift) begin
          data_reg <= {data_reg[DATA_W-2:0], link.data_in};
        end else begin
          data_reg <= mem[addr_reg];
        end
      end
    end
  end

  // msb is a flop bit, so it settles within the first clock
  assign link.data_out = data_reg[DATA_W-1];

  // operation sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state    <= S_IDLE;
      op_cnt   <= '0;
      op_erase <= 1'b0;
      commit   <= 1'b0;
      idle     <= 1'b1;
      refused  <= 1'b0;
      link.busy <= 1'b0;
    end else if (ce) begin
      commit <= 1'b0;
      unique case (state)
        S_IDLE: begin
          if (p_rise || e_rise) begin
            // without a running oscillator the pump cannot work
            if (link.oscillator_enable) begin
              op_erase <= e_rise & ~p_rise;
              op_cnt   <= cnt_t'(BUSY_LAG_CYC - 1);
              idle     <= 1'b0;
              state    <= S_LAG;
            end else begin
              refused <= 1'b1;
            end
          end
        end
        S_LAG: begin
          op_cnt <= op_cnt - cnt_t'(1);
          if (op_cnt == cnt_t'(0)) begin
            link.busy <= 1'b1;
            if (op_erase) begin
              op_cnt <= cnt_t'(ERASE_CYCLES - 1);
              state  <= S_ERASE;
            end else begin
              op_cnt <= cnt_t'(PROG_CYCLES - 1);
              state  <= S_PROG;
            end
          end
        end
        S_PROG, S_ERASE: begin
          op_cnt <= op_cnt - cnt_t'(1);
          if (op_cnt == cnt_t'(0)) begin
            link.busy <= 1'b0;
            commit    <= 1'b1;
            state     <= S_RELEASE;
          end
        end
        S_RELEASE: begin
          // wait for the request to drop so one request makes one operation
          if (!link.prog_req && !link.erase_req) begin
            idle  <= 1'b1;
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  // array update at the end of busy; erase sets every word of the addressed half to all ones
  always_ff @(posedge clock) begin
    if (ce && commit) begin
      if (op_erase) begin
        for (int i = 0; i < MEM_WORDS; i++) begin
          if (i[ADDR_W-1] == addr_reg[ADDR_W-1]) begin
            mem[i] <= '1;
          end
        end
      end else begin
        // flash can only clear bits
        mem[addr_reg] <= mem[addr_reg] & data_reg;
      end
    end
  end

  // oscillator: start-up delay, then a free square wave while enabled
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      osc_cnt      <= '0;
      osc_started  <= 1'b0;
      link.osc_clk <= 1'b0;
    end else if (ce) begin
      if (!link.oscillator_enable) begin
        osc_cnt      <= '0;
        osc_started  <= 1'b0;
        link.osc_clk <= 1'b0;
      end else if (!osc_started) begin
        osc_cnt <= osc_cnt + cnt_t'(1);
        if (osc_cnt == cnt_t'(OE_CYC - 1)) begin
          osc_started  <= 1'b1;
          osc_cnt      <= '0;
          link.osc_clk <= 1'b1;
        end
      end else begin
        osc_cnt <= osc_cnt + cnt_t'(1);
        if (osc_cnt == cnt_t'(OSC_HALF_CYC - 1)) begin
          osc_cnt      <= '0;
          link.osc_clk <= ~link.osc_clk;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/flash_link_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_link_sva #(
  parameter int unsigned PROG_CYCLES  = flash_pkg::PROG_MAX_CYC,
  parameter int unsigned ERASE_CYCLES = flash_pkg::ERASE_MAX_CYC
) (
  input wire logic clock,             // system clock
  input wire logic rst,               // async reset, active high
  input wire logic arclk,             // address serial clock
  input wire logic drclk,             // data serial clock
  input wire logic data_out,          // data register msb
  input wire logic prog_req,          // program request
  input wire logic erase_req,         // erase request
  input wire logic busy,              // operation running
  input wire logic oscillator_enable, // oscillator run request
  input wire logic osc_clk            // oscillator output
);
  import flash_pkg::*;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  logic [7:0] osc_on;   // cycles with enable high, saturating
  logic [7:0] req_off;  // cycles with both requests low, saturating
  cnt_t       busy_len; // cycles of busy high so far

  // saturating so a long enable never wraps back under the limit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      osc_on <= 8'h00;
    end else if (!oscillator_enable) begin
      osc_on <= 8'h00;
    end else if (osc_on != 8'hFF) begin
      osc_on <= osc_on + 8'h01;
    end
  end

  // starts full: no request has been seen yet after reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      req_off <= 8'hFF;
    end else if (prog_req || erase_req) begin
      req_off <= 8'h00;
    end else if (req_off != 8'hFF) begin
      req_off <= req_off + 8'h01;
    end
  end

  // length of the current busy pulse, kept until the fall is seen
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_len <= '0;
    end else if (!busy) begin
      busy_len <= '0;
    end else begin
      busy_len <= busy_len + cnt_t'(1);
    end
  end

  a_addr_clk_period: assert property ($rose(arclk) |=> (!$rose(arclk)) [*4])
    else $error("address clock period too short");
  a_data_clk_period: assert property ($rose(drclk) |=> (!$rose(drclk)) [*4])
    else $error("data clock period too short");
  a_prog_busy_rise: assert property ($rose(prog_req) |-> ##[1:48] $rose(busy))
    else $error("busy late after program request");
  a_prog_hold_after: assert property ($fell(prog_req) |-> !$past(busy))
    else $error("program request dropped too early");
  a_prog_busy_len: assert property ($fell(busy) && prog_req |-> busy_len <= PROG_CYCLES)
    else $error("program busy pulse too long");
  a_erase_busy_rise: assert property ($rose(erase_req) |-> ##[1:48] $rose(busy))
    else $error("busy late after erase request");
  a_erase_hold_after: assert property ($fell(erase_req) |-> !$past(busy))
    else $error("erase request dropped too early");
  a_erase_busy_len: assert property ($fell(busy) && erase_req |-> busy_len <= ERASE_CYCLES)
    else $error("erase busy pulse too long");
  a_data_out_cause: assert property ($changed(data_out) |-> $past(drclk) && !$past(drclk, 2))
    else $error("data output moved without a data clock rise");
  a_osc_first_rise: assert property ($rose(osc_clk) |-> osc_on >= OE_CYC)
    else $error("oscillator rose too soon after enable");
  a_osc_lead_time: assert property ($rose(prog_req) || $rose(erase_req)
    |-> osc_on >= OSCS_CYC)
    else $error("request raised too soon after oscillator enable");
  a_osc_tail_time: assert property ($fell(oscillator_enable) |-> req_off >= OSCS_CYC)
    else $error("oscillator enable dropped too soon");
  a_busy_quiet_link: assert property (busy |-> !$rose(arclk) && !$rose(drclk)
    && $stable(prog_req) && $stable(erase_req))
    else $error("link activity while busy");

  c_prog_done: cover property ($fell(busy) && prog_req);
  c_erase_done: cover property ($fell(busy) && erase_req);
  c_osc_run: cover property ($rose(osc_clk));
  c_data_move: cover property ($changed(data_out));
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import flash_pkg::*;
  localparam int unsigned P_PROG  = 40;   // shortened program busy
  localparam int unsigned P_ERASE = 60;   // shortened erase busy
  localparam int unsigned T_OUT   = 3000; // bound on every wait, cycles

  logic  clock;       // system clock
  logic  rst;         // reset
  logic  ce;          // clock enable
  logic  start;       // operation start
  op_e   op;          // operation
  addr_t addr;        // word address
  word_t wdata;       // word to program
  logic  ready;       // controller idle
  logic  done;        // completion pulse
  logic  timeout;     // controller timeout flag
  word_t rdata;       // word read back
  logic  idle;        // device idle
  logic  refused;     // device refusal flag
  logic  idle_2;      // second device idle
  logic  refused_2;   // second device refusal flag
  int    num_errors;  // mismatches
  int    checks_done; // comparisons

  flash_link_if link ();
  flash_link_if link_2 (); // driven by the bench to break the rules

  flash_user_ctrl #(.PROG_TIMEOUT(100), .ERASE_TIMEOUT(120)) i_flash_user_ctrl (
    .clock(clock), .rst(rst), .ce(ce), .link(link), .start(start), .op(op), .addr(addr),
    .wdata(wdata), .ready(ready), .done(done), .timeout(timeout), .rdata(rdata));
  user_flash_block #(.PROG_CYCLES(P_PROG), .ERASE_CYCLES(P_ERASE)) i_user_flash_block (
    .clock(clock), .rst(rst), .ce(ce), .link(link), .idle(idle), .refused(refused));
  user_flash_block #(.PROG_CYCLES(P_PROG), .ERASE_CYCLES(P_ERASE)) i_user_flash_block_2 (
    .clock(clock), .rst(rst), .ce(ce), .link(link_2), .idle(idle_2), .refused(refused_2));
  flash_link_sva #(.PROG_CYCLES(P_PROG), .ERASE_CYCLES(P_ERASE)) i_flash_link_sva (
    .clock(clock), .rst(rst), .arclk(link.arclk), .drclk(link.drclk),
    .data_out(link.data_out), .prog_req(link.prog_req), .erase_req(link.erase_req),
    .busy(link.busy), .oscillator_enable(link.oscillator_enable), .osc_clk(link.osc_clk));

  // free-running 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic check_word(input string name, input word_t exp, input word_t got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // inputs always move one nanosecond after the rising edge
  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  task automatic fail_wait(input string what);
    num_errors++;
    $display("MISMATCH wait %s expected 1 seen stuck", what);
    give_verdict();
  endtask

  // one whole host operation, from ready to the done pulse
  task automatic do_op(input op_e o, input addr_t a, input word_t d);
    int n;
    n = 0;
    while (ready !== 1'b1) begin
      tick();
      n++;
      if (n > T_OUT) fail_wait("ready");
    end
    start = 1'b1;
    op = o;
    addr = a;
    wdata = d;
    tick();
    start = 1'b0;
    n = 0;
    while (done !== 1'b1) begin
      tick();
      n++;
      if (n > T_OUT) fail_wait("done");
    end
  endtask

  task automatic rd_check(input string name, input addr_t a, input word_t exp);
    do_op(OP_READ, a, 16'h0000);
    check_word(name, exp, rdata);
  endtask

  task automatic t_reset();
    check_bit("ready", 1'b1, ready);
    check_bit("idle", 1'b1, idle);
    check_bit("busy", 1'b0, link.busy);
    check_bit("refused", 1'b0, refused);
  endtask

  // both halves erased, then 9'h000, 9'h0FF and 9'h1FF read back all ones
  task automatic t_erase_all();
    do_op(OP_ERASE, 9'h000, 16'h0000);
    do_op(OP_ERASE, 9'h100, 16'h0000);
    rd_check("erased_lo", 9'h000, 16'hFFFF);
    rd_check("erased_mid", 9'h0FF, 16'hFFFF);
    rd_check("erased_hi", 9'h1FF, 16'hFFFF);
  endtask

  // programming only clears bits, so a second write ands in
  task automatic t_prog_and();
    do_op(OP_PROG, 9'h005, 16'hA5C3);
    check_bit("osc_off", 1'b0, link.oscillator_enable);
    check_bit("busy_off", 1'b0, link.busy);
    check_bit("idle_after", 1'b1, idle);
    check_bit("refused_ok", 1'b0, refused);
    check_bit("timeout_prog", 1'b0, timeout);
    rd_check("prog_1", 9'h005, 16'hA5C3);
    do_op(OP_PROG, 9'h005, 16'h0FF0);
    rd_check("prog_and", 9'h005, 16'h05C0);
  endtask

  // erase of the low half leaves the high half alone
  task automatic t_sector();
    do_op(OP_PROG, 9'h1FF, 16'h1234);
    do_op(OP_ERASE, 9'h005, 16'h0000);
    rd_check("sector_lo", 9'h005, 16'hFFFF);
    rd_check("sector_hi", 9'h1FF, 16'h1234);
  endtask

  // freeze both ends in mid-read; only reads, since a frozen busy stretches
  task automatic t_freeze();
    fork
      do_op(OP_READ, 9'h1FF, 16'h0000);
      begin
        repeat (60) tick();
        ce = 1'b0;
        repeat (30) tick();
        ce = 1'b1;
      end
    join
    check_word("frozen_read", 16'h1234, rdata);
    check_bit("timeout", 1'b0, timeout);
  endtask

  // program request with the oscillator off must be refused
  task automatic t_refuse();
    link_2.prog_req = 1'b1;
    repeat (60) tick();
    check_bit("refused_2", 1'b1, refused_2);
    check_bit("busy_2", 1'b0, link_2.busy);
    link_2.prog_req = 1'b0;
    tick();
    check_bit("idle_2", 1'b1, idle_2);
  endtask

  initial begin
    num_errors = 0;
    checks_done = 0;
    rst = 1'b1;
    ce = 1'b1;
    start = 1'b0;
    op = OP_READ;
    addr = '0;
    wdata = '0;
    link_2.arclk = 1'b0;
    link_2.addr_shift = 1'b0;
    link_2.addr_in = 1'b0;
    link_2.drclk = 1'b0;
    link_2.data_shift = 1'b0;
    link_2.data_in = 1'b0;
    link_2.prog_req = 1'b0;
    link_2.erase_req = 1'b0;
    link_2.oscillator_enable = 1'b0;
    repeat (6) @(posedge clock);
    #1;
    rst = 1'b0;
    t_reset();
    t_erase_all();
    t_prog_and();
    t_sector();
    t_freeze();
    t_refuse();
    give_verdict();
  end
endmodule
`default_nettype wire
